// ==== inc/eosht_regs.svh ====
// Register offsets, field positions, reset values and mode codes of the one-shot timer.
// Assumes a 32-bit APB register bus with byte addresses.
`ifndef EOSHT_REGS_SVH
`define EOSHT_REGS_SVH

// Byte offsets of the registers
`define EOSHT_OFF_CTRL 8'h00
`define EOSHT_OFF_PERIOD 8'h04
`define EOSHT_OFF_PULSE 8'h08
`define EOSHT_OFF_COUNT 8'h0C
`define EOSHT_OFF_STATUS 8'h10
`define EOSHT_OFF_IRQ_EN 8'h14
`define EOSHT_OFF_IRQ_CLR 8'h18
`define EOSHT_OFF_LIVE 8'h1C

// Control register fields
`define EOSHT_CTRL_RUN_BIT 0
`define EOSHT_CTRL_MODE_LSB 1
`define EOSHT_CTRL_MODE_MSB 5
`define EOSHT_CTRL_PWM_BIT 6

// Event bits shared by status, enable and clear registers
`define EOSHT_EV_START_BIT 0
`define EOSHT_EV_PULSE_BIT 1
`define EOSHT_EV_PERIOD_BIT 2
`define EOSHT_EV_W 3

// Live state register fields
`define EOSHT_LIVE_CNT_BIT 0
`define EOSHT_LIVE_PWM_BIT 1
`define EOSHT_LIVE_ARM_BIT 2

// Trigger edge mode codes
`define EOSHT_MODE_RISE 5'h09
`define EOSHT_MODE_FALL 5'h0A
`define EOSHT_MODE_BOTH 5'h0B

// Reset values
`define EOSHT_RST_CTRL 32'h0000_0000
`define EOSHT_RST_PERIOD 32'h0000_0000
`define EOSHT_RST_PULSE 32'h0000_0000
`define EOSHT_RST_IRQ_EN 32'h0000_0000

`endif

// ==== inc/eosht_pkg.sv ====
// Types of the edge-triggered one-shot timer.
// Assumes the constants of eosht_regs.svh.
package eosht_pkg;

    // Address width of the register bus
    localparam int EOSHT_AW = 8;

    // APB request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [EOSHT_AW-1:0] paddr;
        logic [31:0] pwdata;
    } eosht_apb_req_t;

    // APB answer of the slave
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } eosht_apb_rsp_t;

    // Timer sequencer states
    typedef enum logic [1:0] {
        EOSHT_IDLE = 2'b00,
        EOSHT_ARMED = 2'b01,
        EOSHT_COUNT = 2'b10
    } eosht_state_t;

endpackage : eosht_pkg

// ==== hw/eosht_sync.sv ====
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes sys_clk_i is the only clock; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module eosht_sync (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic async_i,
    output logic sync_o
);

    // First and second stage
    logic meta_q;
    logic sync_q;

    // Shift the level through two flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : eosht_sync

`default_nettype wire

// ==== hw/eosht_edge.sv ====
// Trigger edge qualifier: turns the synchronised trigger level into a start pulse.
// Assumes a synchronised input and a mode field from the control register.
`timescale 1ns/1ps
`default_nettype none

`include "eosht_regs.svh"

module eosht_edge (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic level_i,
    input wire logic [4:0] mode_i,
    input wire logic armed_i,
    output logic fire_o
);

    // Trigger level one cycle earlier
    logic prev_q;

    // True when the mode accepts this pair of levels as an edge
    function automatic logic edge_ok(input logic [4:0] mode, input logic prv, input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prv;
        fall = prv & ~cur;
        edge_ok = ((mode == `EOSHT_MODE_RISE) & rise)
            | ((mode == `EOSHT_MODE_FALL) & fall)
            | ((mode == `EOSHT_MODE_BOTH) & (rise | fall));
    endfunction : edge_ok

    // Track the level always, so an old edge never fires later
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
        end else if (ce_i) begin
            prev_q <= level_i;
        end
    end

    // Edges count only while armed
    assign fire_o = armed_i & edge_ok(mode_i, prev_q, level_i);

endmodule : eosht_edge

`default_nettype wire

// ==== hw/eosht_top.sv ====
// Edge-triggered one-shot timer with period match and PWM drive, APB slave.
// Assumes a 40 MHz sys_clk_i, an asynchronous trigger pin and a zero-wait APB master.
`timescale 1ns/1ps
`default_nettype none

`include "eosht_regs.svh"

module eosht_top
    import eosht_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire eosht_apb_req_t apb_req_i,
    output eosht_apb_rsp_t apb_rsp_o,
    input wire logic external_trigger_input_i,
    output logic pwm_drive_o,
    output logic postscaled_match_output_o,
    output logic [CNT_W-1:0] timer_count_o,
    output logic irq_o
);

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------

    // Run bit, set by software, cleared by hardware on halt
    logic run_q;
    logic run_d;
    // Trigger edge mode
    logic [4:0] mode_q;
    // PWM enable: the drive goes high at the start edge in this mode
    logic pwm_en_q;
    // Period and pulse-width compare values
    logic [CNT_W-1:0] period_value_q;
    logic [CNT_W-1:0] pulse_width_value_q;
    // Sticky event status and its enables
    logic [`EOSHT_EV_W-1:0] status_q;
    logic [`EOSHT_EV_W-1:0] status_d;
    logic [`EOSHT_EV_W-1:0] irq_en_q;
    // Registered read data and error for the access phase
    logic [31:0] prdata_q;
    logic pslverr_q;

    // ---------------------------------------------------------------
    // Timer state
    // ---------------------------------------------------------------

    // Sequencer state
    eosht_state_t state_q;
    eosht_state_t state_d;
    // Running count
    logic [CNT_W-1:0] timer_count_q;
    logic [CNT_W-1:0] timer_count_d;
    // PWM drive level
    logic pwm_q;
    logic pwm_d;
    // One-cycle period match pulse
    logic match_q;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------

    // Setup cycle samples read data; access cycle commits writes
    wire setup_w = apb_req_i.psel & ~apb_req_i.penable;
    wire access_w = apb_req_i.psel & apb_req_i.penable;
    wire wr_w = access_w & apb_req_i.pwrite & ce_i;
    wire [EOSHT_AW-1:0] addr_w = apb_req_i.paddr;
    wire [31:0] wdata_w = apb_req_i.pwdata;

    // Address hits
    wire hit_ctrl_w = (addr_w == `EOSHT_OFF_CTRL);
    wire hit_period_w = (addr_w == `EOSHT_OFF_PERIOD);
    wire hit_pulse_w = (addr_w == `EOSHT_OFF_PULSE);
    wire hit_count_w = (addr_w == `EOSHT_OFF_COUNT);
    wire hit_status_w = (addr_w == `EOSHT_OFF_STATUS);
    wire hit_irq_en_w = (addr_w == `EOSHT_OFF_IRQ_EN);
    wire hit_irq_clr_w = (addr_w == `EOSHT_OFF_IRQ_CLR);
    wire hit_live_w = (addr_w == `EOSHT_OFF_LIVE);

    // Any mapped register
    wire hit_any_w = hit_ctrl_w | hit_period_w | hit_pulse_w | hit_count_w
        | hit_status_w | hit_irq_en_w | hit_irq_clr_w | hit_live_w;

    // Writes to read-only registers are errors too
    wire ro_w = hit_count_w | hit_status_w | hit_live_w;
    wire err_w = ~hit_any_w | (apb_req_i.pwrite & ro_w);

    // Write strobes per register
    wire wr_ctrl_w = wr_w & hit_ctrl_w;
    wire wr_period_w = wr_w & hit_period_w;
    wire wr_pulse_w = wr_w & hit_pulse_w;
    wire wr_irq_en_w = wr_w & hit_irq_en_w;
    wire wr_irq_clr_w = wr_w & hit_irq_clr_w;

    // Control fields as written
    wire wr_run_w = wdata_w[`EOSHT_CTRL_RUN_BIT];
    wire [4:0] wr_mode_w = wdata_w[`EOSHT_CTRL_MODE_MSB:`EOSHT_CTRL_MODE_LSB];

    // ---------------------------------------------------------------
    // Read data mux
    // ---------------------------------------------------------------

    // Control readback
    wire [31:0] rd_ctrl_w = {25'h0000000, pwm_en_q, mode_q, run_q};
    // Live state readback
    wire [31:0] rd_live_w = {29'h00000000, (state_q == EOSHT_ARMED), pwm_q,
        (state_q == EOSHT_COUNT)};
    // Compare values, count, status and enables, widened to the bus
    wire [31:0] rd_period_w = 32'(period_value_q);
    wire [31:0] rd_pulse_w = 32'(pulse_width_value_q);
    wire [31:0] rd_count_w = 32'(timer_count_q);
    wire [31:0] rd_status_w = 32'(status_q);
    wire [31:0] rd_irq_en_w = 32'(irq_en_q);

    // Clear register reads as zero; unmapped reads as zero
    wire [31:0] rdata_w =
        hit_ctrl_w ? rd_ctrl_w :
        hit_period_w ? rd_period_w :
        hit_pulse_w ? rd_pulse_w :
        hit_count_w ? rd_count_w :
        hit_status_w ? rd_status_w :
        hit_irq_en_w ? rd_irq_en_w :
        hit_live_w ? rd_live_w : 32'h0000_0000;

    // ---------------------------------------------------------------
    // Trigger path
    // ---------------------------------------------------------------

    // Synchronised trigger level
    logic trig_sync_w;
    // Qualified start pulse
    logic start_w;

    // Bring the pin into the clock domain
    eosht_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(external_trigger_input_i),
        .sync_o(trig_sync_w)
    );

    // Qualify edges by mode, only while armed
    eosht_edge u_edge (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .level_i(trig_sync_w),
        .mode_i(mode_q),
        .armed_i(state_q == EOSHT_ARMED),
        .fire_o(start_w)
    );

    // ---------------------------------------------------------------
    // Compare logic
    // ---------------------------------------------------------------

    // Timer is counting
    wire counting_w = (state_q == EOSHT_COUNT);
    // Period reached: ends the one-shot interval
    wire period_hit_w = counting_w & (timer_count_q == period_value_q);
    // Pulse width reached: drive goes off
    wire pulse_hit_w = counting_w & (timer_count_q == pulse_width_value_q);

    // ---------------------------------------------------------------
    // Run bit
    // ---------------------------------------------------------------

    // A software write of one wins over the hardware clear
    always_comb begin
        run_d = run_q;
        if (period_hit_w) begin
            run_d = 1'b0;
        end
        if (wr_ctrl_w) begin
            run_d = wr_run_w;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------

    // Next state, count and drive
    always_comb begin
        state_d = state_q;
        timer_count_d = timer_count_q;
        pwm_d = pwm_q;
        unique case (state_q)
            // Stopped: arm as soon as run is set
            EOSHT_IDLE: begin
                timer_count_d = '0;
                pwm_d = 1'b0;
                if (run_q) begin
                    state_d = EOSHT_ARMED;
                end
            end
            // Waiting for a trigger edge
            EOSHT_ARMED: begin
                timer_count_d = '0;
                if (!run_q) begin
                    state_d = EOSHT_IDLE;
                end else if (start_w) begin
                    state_d = EOSHT_COUNT;
                    pwm_d = pwm_en_q;
                end
            end
            // Counting up one per timer clock
            EOSHT_COUNT: begin
                if (!run_q) begin
                    // Software stop resets the count; a fresh edge is needed
                    state_d = EOSHT_IDLE;
                    timer_count_d = '0;
                    pwm_d = 1'b0;
                end else if (period_hit_w) begin
                    state_d = EOSHT_IDLE;
                    timer_count_d = '0;
                    pwm_d = 1'b0;
                end else begin
                    timer_count_d = timer_count_q + 1'b1;
                    if (pulse_hit_w) begin
                        pwm_d = 1'b0;
                    end
                end
            end
            // Illegal code falls back to stopped
            default: begin
                state_d = EOSHT_IDLE;
                timer_count_d = '0;
                pwm_d = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Event status
    // ---------------------------------------------------------------

    // Hardware events of this cycle
    wire [`EOSHT_EV_W-1:0] events_w = {period_hit_w, pulse_hit_w, start_w};
    // Bits software asks to clear
    wire [`EOSHT_EV_W-1:0] clr_w = wr_irq_clr_w ? wdata_w[`EOSHT_EV_W-1:0] : '0;

    // Set wins over clear
    always_comb begin
        status_d = (status_q & ~clr_w) | events_w;
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------

    // Software-written configuration
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= 5'(`EOSHT_RST_CTRL >> `EOSHT_CTRL_MODE_LSB);
            pwm_en_q <= 1'b0;
            period_value_q <= CNT_W'(`EOSHT_RST_PERIOD);
            pulse_width_value_q <= CNT_W'(`EOSHT_RST_PULSE);
            irq_en_q <= `EOSHT_EV_W'(`EOSHT_RST_IRQ_EN);
        end else if (ce_i) begin
            if (wr_ctrl_w) begin
                mode_q <= wr_mode_w;
                pwm_en_q <= wdata_w[`EOSHT_CTRL_PWM_BIT];
            end
            if (wr_period_w) begin
                period_value_q <= wdata_w[CNT_W-1:0];
            end
            if (wr_pulse_w) begin
                pulse_width_value_q <= wdata_w[CNT_W-1:0];
            end
            if (wr_irq_en_w) begin
                irq_en_q <= wdata_w[`EOSHT_EV_W-1:0];
            end
        end
    end

    // Run bit and status
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= 1'b0;
            status_q <= '0;
        end else if (ce_i) begin
            run_q <= run_d;
            status_q <= status_d;
        end
    end

    // Timer state
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= EOSHT_IDLE;
            timer_count_q <= '0;
            pwm_q <= 1'b0;
            match_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            timer_count_q <= timer_count_d;
            pwm_q <= pwm_d;
            match_q <= period_hit_w;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (ce_i && setup_w) begin
            prdata_q <= apb_req_i.pwrite ? 32'h0000_0000 : rdata_w;
            pslverr_q <= err_w;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    // Zero-wait answer; stalls while the clock enable is low
    assign apb_rsp_o.pready = access_w & ce_i;
    assign apb_rsp_o.pslverr = access_w & pslverr_q;
    assign apb_rsp_o.prdata = prdata_q;

    // Drive, match pulse and count straight from flops
    assign pwm_drive_o = pwm_q;
    assign postscaled_match_output_o = match_q;
    assign timer_count_o = timer_count_q;

    // Level interrupt from any enabled sticky event
    assign irq_o = |(status_q & irq_en_q);

endmodule : eosht_top

`default_nettype wire

// ==== sim/eosht_props.sv ====
// Port assertions of the one-shot timer.
// Assumes eosht_top; register values are shadowed from APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "eosht_regs.svh"
module eosht_props
    import eosht_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire eosht_apb_req_t apb_req_i,
    input wire eosht_apb_rsp_t apb_rsp_o,
    input wire logic external_trigger_input_i,
    input wire logic pwm_drive_o,
    input wire logic postscaled_match_output_o,
    input wire logic [CNT_W-1:0] timer_count_o,
    input wire logic irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic wr; // Committed write
    logic qual; // Qualifying pin edge
    logic pin_q;
    logic [3:0] age_q; // Cycles since that edge
    logic [31:0] ctl_q, per_q, pul_q;
    logic [4:0] mode;
    assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && ce_i;
    assign mode = ctl_q[5:1];
    assign qual = (pin_q != external_trigger_input_i) && (mode == `EOSHT_MODE_BOTH
        || (mode == `EOSHT_MODE_RISE && !pin_q) || (mode == `EOSHT_MODE_FALL && pin_q));
    // Shadows of written registers and edge age
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q <= 1'b0;
            age_q <= 4'hF;
            ctl_q <= 32'h0;
            per_q <= 32'h0;
            pul_q <= 32'h0;
        end else begin
            pin_q <= external_trigger_input_i;
            age_q <= qual ? 4'h0 : (age_q == 4'hF || !ce_i ? age_q : age_q + 4'h1);
            if (wr && apb_req_i.paddr == `EOSHT_OFF_CTRL) ctl_q <= apb_req_i.pwdata;
            if (wr && apb_req_i.paddr == `EOSHT_OFF_PERIOD) per_q <= apb_req_i.pwdata;
            if (wr && apb_req_i.paddr == `EOSHT_OFF_PULSE) pul_q <= apb_req_i.pwdata;
        end
    end
    property p_ready;
        apb_req_i.psel && apb_req_i.penable && ce_i |-> apb_rsp_o.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready missing");
    property p_step;
        ce_i && timer_count_o != '0 && !wr |=>
            timer_count_o == $past(timer_count_o) + 1'b1 || timer_count_o == '0;
    endproperty
    a_step: assert property (p_step) else $error("count step wrong");
    property p_start;
        $rose(pwm_drive_o) |-> timer_count_o == '0 && ctl_q[6];
    endproperty
    a_start: assert property (p_start) else $error("drive on off start");
    property p_pulse_off;
        pwm_drive_o && ce_i && !wr && timer_count_o == pul_q[CNT_W-1:0] |=> !pwm_drive_o;
    endproperty
    a_pulse_off: assert property (p_pulse_off) else $error("drive not off");
    property p_halt;
        ce_i && !wr && per_q != 0 && timer_count_o == per_q[CNT_W-1:0] |=>
            postscaled_match_output_o && timer_count_o == '0;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt at period");
    property p_stay_off;
        postscaled_match_output_o |-> !pwm_drive_o [*2];
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("drive on at halt");
    property p_edge;
        timer_count_o == 1 && $past(timer_count_o) == 0 |-> age_q <= 4'h5;
    endproperty
    a_edge: assert property (p_edge) else $error("start without edge");
    property p_bad_mode;
        !(mode inside {`EOSHT_MODE_RISE, `EOSHT_MODE_FALL, `EOSHT_MODE_BOTH})
            && timer_count_o == '0 && !wr |=> timer_count_o == '0;
    endproperty
    a_bad_mode: assert property (p_bad_mode) else $error("start in bad mode");
    property p_freeze;
        !ce_i |=> $stable(timer_count_o) && $stable(pwm_drive_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("timer moved while frozen");
    c_match: cover property (postscaled_match_output_o);
    c_pulse: cover property ($fell(pwm_drive_o));
    c_irq: cover property (irq_o);
endmodule : eosht_props
bind eosht_top eosht_props #(.CNT_W(CNT_W)) eosht_props_i (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
    .external_trigger_input_i(external_trigger_input_i), .pwm_drive_o(pwm_drive_o),
    .postscaled_match_output_o(postscaled_match_output_o),
    .timer_count_o(timer_count_o), .irq_o(irq_o));
`default_nettype wire

// ==== sim/eosht_trig_src.sv ====
// External trigger source model.
// Assumes one request pulse per level change.
`timescale 1ns/1ps
`default_nettype none
module eosht_trig_src (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic flip_i,
    output logic trig_o
);
    // Pin level toggles on each request
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_o <= 1'b0;
        end else if (flip_i) begin
            trig_o <= !trig_o;
        end
    end
endmodule : eosht_trig_src
`default_nettype wire

// ==== sim/edge_triggered_one_shot_timer_tb.sv ====
// Self-checking bench of the one-shot timer.
// Assumes eosht_top, the trigger model and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "eosht_regs.svh"
module edge_triggered_one_shot_timer_tb;
    import eosht_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic flip = 1'b0;
    logic ce = 1'b1;
    logic trig, pwm, match, irq;
    logic [15:0] cnt;
    eosht_apb_req_t req = '0;
    eosht_apb_rsp_t rsp;
    int mismatches = 0;
    int checks_done = 0;
    int seed = 92;
    int per, pul, k;
    logic [4:0] modes[3] = '{`EOSHT_MODE_RISE, `EOSHT_MODE_FALL, `EOSHT_MODE_BOTH};
    logic [33:0] notes[$]; // Bit 33 data unchecked, bit 32 error
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    eosht_top #(.CNT_W(16)) eosht_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .apb_req_i(req), .apb_rsp_o(rsp), .external_trigger_input_i(trig),
        .pwm_drive_o(pwm), .postscaled_match_output_o(match), .timer_count_o(cnt),
        .irq_o(irq));
    eosht_trig_src eosht_trig_src_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .flip_i(flip), .trig_o(trig));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask : tick
    // One APB transfer; the note is checked when it completes
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [33:0] note);
        notes.push_back(note);
        @(posedge sys_clk_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
        end while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(a, 1'b1, d, {1'b1, err, 32'h0});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, {2'b00, exp});
    endtask : rd
    // One level change of the trigger pin, back at the edge that makes it
    task automatic pulse_pin();
        @(posedge sys_clk_i);
        flip <= 1'b1;
        @(posedge sys_clk_i);
        flip <= 1'b0;
    endtask : pulse_pin
    // Level change followed by time for it to settle
    task automatic flip_pin();
        pulse_pin();
        repeat (10) tick();
    endtask : flip_pin
    // Qualifying edge, after a refused one where the next change of the pin would be refused
    task automatic fire(input logic [4:0] m);
        if (!(m == `EOSHT_MODE_BOTH || (m == `EOSHT_MODE_RISE) == (trig == 1'b0))) begin
            flip_pin();
            rd(`EOSHT_OFF_COUNT, 32'h0);
        end
        pulse_pin();
    endtask : fire
    // Walk of one shot from the start edge to the halt
    task automatic shot();
        int i;
        for (i = 0; i < 40 && pwm !== 1'b1; i++) tick();
        check({pwm, i[7:0]}, 9'h103);
        for (i = 0; i <= per; i++) begin
            check(cnt, i[15:0]);
            check({pwm, match}, {i <= pul, 1'b0});
            tick();
        end
        check({match, pwm, cnt}, 18'h20000);
    endtask : shot
    // Monitor takes the oldest note at each completed transfer
    always @(posedge sys_clk_i) begin
        logic [33:0] e;
        if (req.psel && req.penable && rsp.pready === 1'b1) begin
            e = notes.pop_front();
            check(rsp.pslverr, e[32]);
            if (!e[33]) check(rsp.prdata, e[31:0]);
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (k = 0; k < 32; k += 4) rd(k[7:0], 32'h0);
        apb(8'h20, 1'b0, 32'h0, {2'b11, 32'h0});
        wr(`EOSHT_OFF_COUNT, 32'h1, 1'b1);
        wr(`EOSHT_OFF_IRQ_EN, 32'h7, 1'b0);
        foreach (modes[j]) begin
            per = 3 + ($random(seed) & 7);
            pul = ($random(seed) & 7) % per;
            wr(`EOSHT_OFF_PERIOD, per, 1'b0);
            wr(`EOSHT_OFF_PULSE, pul, 1'b0);
            flip_pin();
            rd(`EOSHT_OFF_COUNT, 32'h0);
            wr(`EOSHT_OFF_CTRL, {26'h1, modes[j], 1'b1}, 1'b0);
            fire(modes[j]);
            shot();
            rd(`EOSHT_OFF_CTRL, {26'h1, modes[j], 1'b0});
            rd(`EOSHT_OFF_STATUS, 32'h7);
            check(irq, 1'b1);
            wr(`EOSHT_OFF_IRQ_CLR, 32'h7, 1'b0);
            rd(`EOSHT_OFF_STATUS, 32'h0);
            check(irq, 1'b0);
        end
        // Armed in a code that is no one-shot mode: edges never start
        wr(`EOSHT_OFF_CTRL, {26'h1, 5'h0C, 1'b1}, 1'b0);
        flip_pin();
        flip_pin();
        rd(`EOSHT_OFF_COUNT, 32'h0);
        wr(`EOSHT_OFF_CTRL, {26'h1, `EOSHT_MODE_RISE, 1'b1}, 1'b0);
        fire(`EOSHT_MODE_RISE);
        // Freeze right after the start edge, then stop by software
        repeat (3) @(posedge sys_clk_i);
        ce <= 1'b0;
        repeat (3) tick();
        check({pwm, cnt}, 17'h10000);
        @(posedge sys_clk_i);
        ce <= 1'b1;
        wr(`EOSHT_OFF_CTRL, {26'h1, `EOSHT_MODE_RISE, 1'b0}, 1'b0);
        rd(`EOSHT_OFF_COUNT, 32'h0);
        wr(`EOSHT_OFF_CTRL, {26'h1, `EOSHT_MODE_RISE, 1'b1}, 1'b0);
        repeat (10) tick();
        rd(`EOSHT_OFF_LIVE, 32'h4);
        wr(`EOSHT_OFF_IRQ_EN, 32'h0, 1'b0);
        fire(`EOSHT_MODE_RISE);
        shot();
        rd(`EOSHT_OFF_STATUS, 32'h7);
        check(irq, 1'b0);
        conclude();
    end
    initial begin
        #(25 * 30000);
        mismatches++;
        conclude();
    end
endmodule : edge_triggered_one_shot_timer_tb
`default_nettype wire
